/* range_pkg.sv */
// Constants shared by the memory-type range unit and its self-checking bench.
// Assumes a single core clock domain and software access via model registers.
package range_pkg;

   // Memory type encodings
   localparam logic [7:0] UNCACHEABLE_TYPE     = 8'h00;
   localparam logic [7:0] WRITE_COMBINING_TYPE = 8'h01;
   localparam logic [7:0] WRITE_THROUGH_TYPE   = 8'h04;
   localparam logic [7:0] WRITE_PROTECTED_TYPE = 8'h05;
   localparam logic [7:0] WRITE_BACK_TYPE      = 8'h06;

   // Model register indices
   localparam int         INDEX_W        = 12;
   localparam logic [11:0] IDX_RANGE_CAP  = 12'h000;
   localparam logic [11:0] IDX_DEF_TYPE   = 12'h001;
   localparam logic [11:0] IDX_FIX_BASE   = 12'h010;
   localparam logic [11:0] IDX_VAR_BASE   = 12'h020;
   localparam int         FIX_COUNT      = 11;

   // Capability register field positions
   localparam int CAP_COUNT_LSB    = 0;
   localparam int CAP_FIX_BIT      = 8;
   localparam int CAP_COMBINE_BIT  = 10;
   localparam int CAP_SYS_MGMT_BIT = 11;

   // Default type register fields
   localparam int          DEF_FE_BIT      = 10;
   localparam int          DEF_E_BIT       = 11;
   localparam logic [63:0] DEF_WRITABLE    = 64'h0000_0000_0000_0CFF;
   localparam logic [63:0] DEF_RESET       = 64'h0000_0000_0000_0000;

   // Variable range pair fields
   localparam int          MASK_VALID_BIT  = 11;
   localparam logic [63:0] BASE_LOW_RSVD   = 64'h0000_0000_0000_0F00;
   localparam logic [63:0] MASK_LOW_RSVD   = 64'h0000_0000_0000_07FF;
   localparam logic [63:0] PAGE_OFFSET     = 64'h0000_0000_0000_0FFF;

   // Fixed range layout over the first megabyte
   localparam int         FIXED_SHIFT     = 20;
   localparam logic [19:0] FIX16K_START   = 20'h80000;
   localparam logic [19:0] FIX4K_START    = 20'hC0000;
   localparam int         FIX_WORD_16K    = 1;
   localparam int         FIX_WORD_4K     = 3;

   // Identification word bit announcing the range mechanism
   localparam int FEATURE_RANGE_BIT = 12;

   // Control states, one-hot
   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_FETCH = 3'b010,
      S_USE   = 3'b100
   } state_t;

   // What the word being fetched is for
   typedef enum logic [1:0] {
      P_REG  = 2'b00,
      P_FIX  = 2'b01,
      P_BASE = 2'b10,
      P_MASK = 2'b11
   } purpose_t;

   // Accepted memory type encodings
   function automatic logic type_legal(input logic [7:0] t, input logic combine_ok);
      type_legal = (t == UNCACHEABLE_TYPE) || (t == WRITE_THROUGH_TYPE) ||
                   (t == WRITE_PROTECTED_TYPE) || (t == WRITE_BACK_TYPE) ||
                   (combine_ok && (t == WRITE_COMBINING_TYPE));
   endfunction : type_legal

   // Overlap resolution between matching variable ranges
   function automatic logic [7:0] merge_type(input logic hit, input logic [7:0] acc,
                                             input logic [7:0] t);
      if (!hit)
         merge_type = t;
      else if ((acc == UNCACHEABLE_TYPE) || (t == UNCACHEABLE_TYPE))
         merge_type = UNCACHEABLE_TYPE;
      else if ((acc == WRITE_THROUGH_TYPE) || (t == WRITE_THROUGH_TYPE))
         merge_type = (acc == WRITE_BACK_TYPE || t == WRITE_BACK_TYPE ||
                       acc == t) ? WRITE_THROUGH_TYPE : acc;
      else
         merge_type = acc;
   endfunction : merge_type

endpackage : range_pkg

/* range_store.sv */
// Small register-file memory for fixed range words and variable range pairs.
// Assumes one access per cycle; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none
module range_store #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 27,
   parameter int AW    = 5
) (
   input  wire logic             ref_clk_i,   // Core clock
   input  wire logic             sys_rst_i,   // Synchronous reset
   input  wire logic             we_i,        // Write strobe
   input  wire logic [AW-1:0]    waddr_i,     // Write word
   input  wire logic [WIDTH-1:0] wdata_i,     // Write data
   input  wire logic [AW-1:0]    raddr_i,     // Read word
   output logic      [WIDTH-1:0] rdata_o      // Registered read data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Storage, cleared so every range reads as uncacheable after reset
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Registered read port
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule : range_store
`default_nettype wire

/* range_unit.sv */
// Memory-type range unit: capability, default type, fixed and variable ranges.
// Assumes software reaches it through single model register reads and writes.
// Functional notes
// - Up to 96 ranges exist: 88 fixed sub-ranges plus the variable ranges.
// - Memory types are 00H uncacheable, 01H combining, 04H through, 05H protected, 06H back.
// - Writing a reserved type code (02H, 03H, 07H-FFH) faults and is not stored.
// - Reset disables every fixed and variable range, leaving memory uncacheable.
// - The identification word reports the range mechanism in bit 12.
// - The capability register is 64 bits, readable and read-only.
// - Capability bits 7:0 give the number of variable ranges.
// - Capability bit 8 is set when fixed ranges exist.
// - Capability bit 10 is set when write combining is supported.
// - Capability bit 11 is set when the system-management range interface exists.
// - A write to the capability register faults and leaves it unchanged.
// - Capability bit 9 and bits 12 to 63 are reserved.
// - Any range register write that does not fault flushes every translation cache entry, global too.
// - With the global enable clear, all memory is uncacheable.
`timescale 1ns/1ps
`default_nettype none
module range_unit #(
   parameter logic [7:0] VAR_COUNT        = 8'd8,
   parameter int         PA_W             = 36,
   parameter logic       FIX_PRESENT      = 1'b1,
   parameter logic       COMBINE_PRESENT  = 1'b1,
   parameter logic       SYS_MGMT_PRESENT = 1'b1
) (
   input  wire logic            ref_clk_i,                  // Core clock
   input  wire logic            sys_rst_i,                  // Synchronous reset
   input  wire logic            reg_req_i,                  // Register access pulse
   input  wire logic            reg_write_i,                // 1 write, 0 read
   input  wire logic [11:0]     reg_index_i,                // Register index
   input  wire logic [63:0]     reg_wdata_i,                // Write data
   output logic                 reg_ready_o,                // Unit idle
   output logic                 reg_ack_o,                  // Access done
   output logic [63:0]          reg_rdata_o,                // Read data
   output logic                 general_protection_fault_o, // Access refused
   output logic                 translation_cache_flush_o,  // Flush all entries
   input  wire logic            query_req_i,                // Type lookup pulse
   input  wire logic [PA_W-1:0] query_addr_i,               // Physical address
   output logic                 query_ack_o,                // Lookup done
   output logic [7:0]           query_type_o,               // Resolved type
   output logic [31:0]          feature_info_word_o         // Identification word
);
   localparam int DEPTH = range_pkg::FIX_COUNT + 2 * int'(VAR_COUNT);
   localparam int AW    = $clog2(DEPTH);
   localparam logic [11:0] VAR_SPAN = 12'(2 * int'(VAR_COUNT));
   localparam logic [63:0] PA_MASK  = (64'h1 << PA_W) - 64'h1;
   localparam logic [63:0] CAP_VALUE =
      (64'(VAR_COUNT) << range_pkg::CAP_COUNT_LSB) |
      (64'(FIX_PRESENT) << range_pkg::CAP_FIX_BIT) |
      (64'(COMBINE_PRESENT) << range_pkg::CAP_COMBINE_BIT) |
      (64'(SYS_MGMT_PRESENT) << range_pkg::CAP_SYS_MGMT_BIT);

   range_pkg::state_t   state;
   range_pkg::purpose_t purpose;
   logic [AW-1:0]   ptr;
   logic [63:0]     def_cfg;
   logic [63:0]     qaddr;
   logic [63:0]     base_q;
   logic [7:0]      var_n;
   logic [2:0]      fix_sel;
   logic            hit;
   logic [7:0]      acc;
   logic [63:0]     mem_rdata;
   logic [11:0]     rel_fix;
   logic [11:0]     rel_var;
   logic            is_cap, is_def, is_fix, is_var, is_mask, mapped;
   logic            bytes_ok, wr_fault, take_reg, take_query, mem_we;
   logic [AW-1:0]   word;
   logic [AW-1:0]   fix_word;
   logic [2:0]      fix_byte;
   logic [63:0]     vmsk;
   logic            vmatch;
   logic [7:0]      next_acc;
   logic            def_e, def_fe;
   logic [7:0]      def_type;

   assign def_e    = def_cfg[range_pkg::DEF_E_BIT];
   assign def_fe   = def_cfg[range_pkg::DEF_FE_BIT];
   assign def_type = def_cfg[7:0];

   // Register index decode and write checks
   always_comb begin
      rel_fix  = reg_index_i - range_pkg::IDX_FIX_BASE;
      rel_var  = reg_index_i - range_pkg::IDX_VAR_BASE;
      is_cap   = reg_index_i == range_pkg::IDX_RANGE_CAP;
      is_def   = reg_index_i == range_pkg::IDX_DEF_TYPE;
      is_fix   = FIX_PRESENT && (reg_index_i >= range_pkg::IDX_FIX_BASE) &&
                 (rel_fix < 12'(range_pkg::FIX_COUNT));
      is_var   = (reg_index_i >= range_pkg::IDX_VAR_BASE) && (rel_var < VAR_SPAN);
      is_mask  = rel_var[0];
      mapped   = is_cap | is_def | is_fix | is_var;
      word     = is_fix ? AW'(rel_fix) : AW'(rel_var + 12'(range_pkg::FIX_COUNT));
      bytes_ok = 1'b1;
      for (int b = 0; b < 8; b++) begin
         bytes_ok = bytes_ok & range_pkg::type_legal(reg_wdata_i[8*b +: 8], COMBINE_PRESENT);
      end
      wr_fault = is_cap | !mapped;
      if (is_def)
         wr_fault = ((reg_wdata_i & ~range_pkg::DEF_WRITABLE) != 64'h0) ||
                    !range_pkg::type_legal(reg_wdata_i[7:0], COMBINE_PRESENT);
      if (is_fix)
         wr_fault = !bytes_ok;
      if (is_var && !is_mask)
         wr_fault = ((reg_wdata_i & (range_pkg::BASE_LOW_RSVD | ~PA_MASK)) != 64'h0) ||
                    !range_pkg::type_legal(reg_wdata_i[7:0], COMBINE_PRESENT);
      if (is_var && is_mask)
         wr_fault = (reg_wdata_i & (range_pkg::MASK_LOW_RSVD | ~PA_MASK)) != 64'h0;
   end

   // Request acceptance; register access wins over a lookup in the same cycle
   assign take_reg   = (state == range_pkg::S_IDLE) && reg_req_i;
   assign take_query = (state == range_pkg::S_IDLE) && !reg_req_i && query_req_i;
   assign mem_we     = take_reg && reg_write_i && !wr_fault && (is_fix || is_var);

   // Fixed range word and byte for the queried address
   always_comb begin
      if (query_addr_i[19:0] < range_pkg::FIX16K_START) begin
         fix_word = '0;
         fix_byte = query_addr_i[18:16];
      end else if (query_addr_i[19:0] < range_pkg::FIX4K_START) begin
         fix_word = AW'(range_pkg::FIX_WORD_16K + int'(query_addr_i[17]));
         fix_byte = query_addr_i[16:14];
      end else begin
         fix_word = AW'(range_pkg::FIX_WORD_4K + int'(query_addr_i[17:15]));
         fix_byte = query_addr_i[14:12];
      end
   end

   // Variable range match against the mask word now on the read port
   always_comb begin
      vmsk     = mem_rdata & PA_MASK & ~range_pkg::PAGE_OFFSET;
      vmatch   = mem_rdata[range_pkg::MASK_VALID_BIT] && ((qaddr & vmsk) == (base_q & vmsk));
      next_acc = vmatch ? range_pkg::merge_type(hit, acc, base_q[7:0]) : acc;
   end

   range_store #(
      .WIDTH (64),
      .DEPTH (DEPTH),
      .AW    (AW)
   ) u_store (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (mem_we),
      .waddr_i   (word),
      .wdata_i   (reg_wdata_i),
      .raddr_i   (ptr),
      .rdata_o   (mem_rdata)
   );

   // Default type and global enable; reset leaves every range disabled
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         def_cfg <= range_pkg::DEF_RESET;
      end else if (take_reg && reg_write_i && is_def && !wr_fault) begin
         def_cfg <= reg_wdata_i;
      end
   end

   // Identification word with the range flag
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         feature_info_word_o <= '0;
      end else begin
         feature_info_word_o <= 32'h1 << range_pkg::FEATURE_RANGE_BIT;
      end
   end

   // Access and lookup sequencer
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state                      <= range_pkg::S_IDLE;
         purpose                    <= range_pkg::P_REG;
         ptr                        <= '0;
         qaddr                      <= '0;
         base_q                     <= '0;
         var_n                      <= '0;
         fix_sel                    <= '0;
         hit                        <= 1'b0;
         acc                        <= '0;
         reg_ready_o                <= 1'b1;
         reg_ack_o                  <= 1'b0;
         reg_rdata_o                <= '0;
         general_protection_fault_o <= 1'b0;
         translation_cache_flush_o  <= 1'b0;
         query_ack_o                <= 1'b0;
         query_type_o               <= range_pkg::UNCACHEABLE_TYPE;
      end else begin
         reg_ack_o                  <= 1'b0;
         general_protection_fault_o <= 1'b0;
         translation_cache_flush_o  <= 1'b0;
         query_ack_o                <= 1'b0;
         unique case (state)
            range_pkg::S_IDLE: begin
               if (take_reg && reg_write_i) begin
                  reg_ack_o                  <= 1'b1;
                  general_protection_fault_o <= wr_fault;
                  translation_cache_flush_o  <= !wr_fault;
               end else if (take_reg && (is_cap || is_def || !mapped)) begin
                  reg_ack_o                  <= 1'b1;
                  general_protection_fault_o <= !mapped;
                  reg_rdata_o                <= is_cap ? CAP_VALUE :
                                                (is_def ? def_cfg : 64'h0);
               end else if (take_reg) begin
                  ptr         <= word;
                  purpose     <= range_pkg::P_REG;
                  state       <= range_pkg::S_FETCH;
                  reg_ready_o <= 1'b0;
               end else if (take_query) begin
                  qaddr   <= 64'(query_addr_i);
                  fix_sel <= fix_byte;
                  hit     <= 1'b0;
                  var_n   <= '0;
                  if (!def_e) begin
                     query_ack_o  <= 1'b1;
                     query_type_o <= range_pkg::UNCACHEABLE_TYPE;
                  end else if (def_fe && FIX_PRESENT &&
                               (query_addr_i >> range_pkg::FIXED_SHIFT) == '0) begin
                     ptr         <= fix_word;
                     purpose     <= range_pkg::P_FIX;
                     state       <= range_pkg::S_FETCH;
                     reg_ready_o <= 1'b0;
                  end else if (VAR_COUNT == 8'd0) begin
                     query_ack_o  <= 1'b1;
                     query_type_o <= def_type;
                  end else begin
                     ptr         <= AW'(range_pkg::FIX_COUNT);
                     purpose     <= range_pkg::P_BASE;
                     state       <= range_pkg::S_FETCH;
                     reg_ready_o <= 1'b0;
                  end
               end
            end
            range_pkg::S_FETCH: begin
               state <= range_pkg::S_USE;
            end
            range_pkg::S_USE: begin
               unique case (purpose)
                  range_pkg::P_REG: begin
                     reg_rdata_o <= mem_rdata;
                     reg_ack_o   <= 1'b1;
                     state       <= range_pkg::S_IDLE;
                     reg_ready_o <= 1'b1;
                  end
                  range_pkg::P_FIX: begin
                     query_type_o <= mem_rdata[8*fix_sel +: 8];
                     query_ack_o  <= 1'b1;
                     state        <= range_pkg::S_IDLE;
                     reg_ready_o  <= 1'b1;
                  end
                  range_pkg::P_BASE: begin
                     base_q  <= mem_rdata;
                     ptr     <= ptr + AW'(1);
                     purpose <= range_pkg::P_MASK;
                     state   <= range_pkg::S_FETCH;
                  end
                  range_pkg::P_MASK: begin
                     hit <= hit | vmatch;
                     acc <= next_acc;
                     if (var_n == VAR_COUNT - 8'd1) begin
                        query_type_o <= (hit | vmatch) ? next_acc : def_type;
                        query_ack_o  <= 1'b1;
                        state        <= range_pkg::S_IDLE;
                        reg_ready_o  <= 1'b1;
                     end else begin
                        var_n   <= var_n + 8'd1;
                        ptr     <= ptr + AW'(1);
                        purpose <= range_pkg::P_BASE;
                        state   <= range_pkg::S_FETCH;
                     end
                  end
               endcase
            end
         endcase
      end
   end

   // Checks on the software-visible behaviour
   a_cap_write_fault: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && reg_write_i && is_cap) |=>
         (reg_ack_o && general_protection_fault_o && !translation_cache_flush_o))
      else $error("capability write not refused");
   a_cap_read_value: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && !reg_write_i && is_cap) |=> (reg_ack_o && reg_rdata_o == CAP_VALUE &&
         reg_rdata_o[7:0] == VAR_COUNT && reg_rdata_o[9] == 1'b0))
      else $error("capability read value wrong");
   a_cap_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && !reg_write_i && is_cap) |=> (reg_rdata_o[63:12] == 52'h0))
      else $error("reserved capability bits not zero");
   a_bad_type_fault: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && reg_write_i && is_def && (reg_wdata_i[7:0] == 8'h02 ||
         reg_wdata_i[7:0] >= 8'h07)) |=> (general_protection_fault_o && $stable(def_cfg)))
      else $error("reserved type accepted");
   a_flush_on_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && reg_write_i && (is_fix || is_var) && !wr_fault) |=>
         (translation_cache_flush_o && !general_protection_fault_o))
      else $error("range write did not flush");
   a_disabled_uc: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_query && !def_e) |=> (query_ack_o && query_type_o == 8'h00))
      else $error("disabled ranges not uncacheable");
   a_reset_disables: assert property (@(posedge ref_clk_i)
      $fell(sys_rst_i) |-> (!def_e && reg_ready_o && state == range_pkg::S_IDLE))
      else $error("ranges enabled after reset");
   a_range_read_lat: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      (take_reg && !reg_write_i && (is_fix || is_var)) |=> !reg_ack_o ##1 !reg_ack_o ##1
         (reg_ack_o && reg_ready_o))
      else $error("range read latency wrong");
   a_feature_flag: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
      $past(!sys_rst_i) |-> (feature_info_word_o[12] == 1'b1))
      else $error("range feature flag missing");
endmodule : range_unit
`default_nettype wire

/* range_unit_tb.sv */
// Self-checking bench for the memory-type range unit: random type codes and corner cases.
// Assumes the unit's default parameters and a 125 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module range_unit_tb;
   logic        ref_clk_i, sys_rst_i, reg_req_i, reg_write_i, query_req_i;
   logic [11:0] reg_index_i;
   logic [63:0] reg_wdata_i, reg_rdata_o, rd, map_word;
   logic [35:0] query_addr_i;
   logic        reg_ready_o, reg_ack_o, fault_o, flush_o, query_ack_o, flt, fls, rdy;
   logic [7:0]  query_type_o, qt, code, last_def;
   logic [31:0] feature_info_word_o;
   logic [15:0] lfsr;
   int          n_errors, n_checks, i;

   range_unit i_range_unit (
      .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i),
      .reg_write_i(reg_write_i), .reg_index_i(reg_index_i), .reg_wdata_i(reg_wdata_i),
      .reg_ready_o(reg_ready_o), .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o),
      .general_protection_fault_o(fault_o), .translation_cache_flush_o(flush_o),
      .query_req_i(query_req_i), .query_addr_i(query_addr_i), .query_ack_o(query_ack_o),
      .query_type_o(query_type_o), .feature_info_word_o(feature_info_word_o));

   // Core clock, 8 ns period
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end

   // Random source and expectation helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   function automatic logic type_reserved(input logic [7:0] t);
      type_reserved = !(t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06});
   endfunction : type_reserved
   function automatic logic [63:0] cap_expected(input logic [7:0] variable_range_count, input logic fx,
                                                input logic cb, input logic sm);
      cap_expected = {52'h0, sm, cb, 1'b0, fx, variable_range_count};
   endfunction : cap_expected

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick();
      @(posedge ref_clk_i);
      #1;
   endtask : tick

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // One register access: request held one edge, answer awaited under a bound
   task automatic reg_op(input logic wr, input logic [11:0] idx, input logic [63:0] wd);
      int n;
      logic late;
      for (n = 0; n < 50 && reg_ready_o !== 1'b1; n++) tick();
      late = (n == 50);
      reg_req_i = 1'b1;
      reg_write_i = wr;
      reg_index_i = idx;
      reg_wdata_i = wd;
      tick();
      reg_req_i = 1'b0;
      for (n = 0; n < 10 && reg_ack_o !== 1'b1; n++) tick();
      late = late | (n == 10);
      rd = reg_rdata_o;
      flt = fault_o;
      fls = flush_o;
      tick();
      if (late) begin
         n_errors++;
         final_report();
      end
   endtask : reg_op

   // One type lookup, the variable scan taking up to 32 cycles
   task automatic query(input logic [35:0] a);
      int n;
      logic late;
      for (n = 0; n < 50 && reg_ready_o !== 1'b1; n++) tick();
      late = (n == 50);
      query_req_i = 1'b1;
      query_addr_i = a;
      tick();
      query_req_i = 1'b0;
      rdy = reg_ready_o;
      for (n = 0; n < 60 && query_ack_o !== 1'b1; n++) tick();
      late = late | (n == 60);
      qt = query_type_o;
      tick();
      if (late) begin
         n_errors++;
         final_report();
      end
   endtask : query

   // Main sequence
   initial begin
      {sys_rst_i, reg_req_i, reg_write_i, query_req_i} = 4'h8;
      reg_index_i = 12'h000;
      reg_wdata_i = 64'h0;
      query_addr_i = 36'h0;
      lfsr = 16'h6E99;
      last_def = 8'h00;
      n_errors = 0;
      n_checks = 0;
      repeat (10) tick();
      sys_rst_i = 1'b0;
      tick();
      check("feature", {32'h0, feature_info_word_o}, 64'h0000_0000_0000_1000);
      reg_op(1'b0, range_pkg::IDX_RANGE_CAP, 64'h0);
      check("capability", rd, cap_expected(8'h08, 1'b1, 1'b1, 1'b1));
      reg_op(1'b0, range_pkg::IDX_FIX_BASE, 64'h0);
      check("fixed_reset", rd, 64'h0);
      query({lfsr, lfsr, lfsr[3:0]});
      check("type_reset", {56'h0, qt}, 64'h0);
      $display("Test reset state done");
      reg_op(1'b1, range_pkg::IDX_RANGE_CAP, {lfsr, lfsr, lfsr, lfsr});
      check("cap_write", {62'h0, flt, fls}, 64'h2);
      reg_op(1'b0, range_pkg::IDX_RANGE_CAP, 64'h0);
      check("cap_kept", rd, cap_expected(8'h08, 1'b1, 1'b1, 1'b1));
      $display("Test capability write done");
      for (i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         code = (i < 16) ? 8'(i) : lfsr[7:0];
         if (!i[0] && !type_reserved(code))
            last_def = code;
         reg_op(1'b1, i[0] ? range_pkg::IDX_VAR_BASE : range_pkg::IDX_DEF_TYPE, {56'h0, code});
         check("fault", {63'h0, flt}, {63'h0, type_reserved(code)});
         check("flush", {63'h0, fls}, {63'h0, !type_reserved(code)});
      end
      reg_op(1'b0, range_pkg::IDX_DEF_TYPE, 64'h0);
      check("def_kept", rd, {56'h0, last_def});
      query({lfsr, lfsr, lfsr[3:0]});
      check("type_disabled", {56'h0, qt}, 64'h0);
      $display("Test type codes done");
      reg_op(1'b1, range_pkg::IDX_DEF_TYPE, 64'h0000_0000_0000_0806);
      query({lfsr, lfsr, lfsr[3:0]});
      check("type_enabled", {56'h0, qt}, 64'h0000_0000_0000_0006);
      sys_rst_i = 1'b1;
      tick();
      sys_rst_i = 1'b0;
      tick();
      reg_op(1'b0, range_pkg::IDX_DEF_TYPE, 64'h0);
      check("def_after_reset", rd, 64'h0);
      query({lfsr, lfsr, lfsr[3:0]});
      check("type_after_reset", {56'h0, qt}, 64'h0);
      $display("Test enable and reset done");
      // Fixed and variable map with overlap, lookups through each path
      lfsr = lfsr_next(lfsr);
      map_word = 64'h0006_0504_0100_0605;
      reg_op(1'b1, range_pkg::IDX_DEF_TYPE, 64'h0000_0000_0000_0C05);
      reg_op(1'b1, range_pkg::IDX_FIX_BASE, map_word);
      check("fix_write", {62'h0, flt, fls}, 64'h1);
      reg_op(1'b1, range_pkg::IDX_FIX_BASE + 12'h001, 64'h0404_0404_0404_0704);
      check("fix_bad_byte", {62'h0, flt, fls}, 64'h2);
      reg_op(1'b0, range_pkg::IDX_FIX_BASE + 12'h001, 64'h0);
      check("fix_refused", rd, 64'h0);
      reg_op(1'b0, range_pkg::IDX_FIX_BASE, 64'h0);
      check("map_kept", rd, map_word);
      query({16'h0, 1'b0, lfsr[2:0], lfsr});
      check("type_fixed", {56'h0, qt}, {56'h0, map_word[8*lfsr[2:0] +: 8]});
      reg_op(1'b1, range_pkg::IDX_VAR_BASE, 64'h0000_0008_0000_0004);
      reg_op(1'b1, range_pkg::IDX_VAR_BASE + 12'h001, 64'h0000_000F_0000_0800);
      reg_op(1'b1, range_pkg::IDX_VAR_BASE + 12'h002, 64'h0000_0008_0000_0006);
      reg_op(1'b1, range_pkg::IDX_VAR_BASE + 12'h003, 64'h0000_000C_0000_0800);
      check("mask_write", {62'h0, flt, fls}, 64'h1);
      query({4'h8, lfsr, lfsr});
      check("type_overlap", {56'h0, qt}, 64'h4);
      check("busy", {63'h0, rdy}, 64'h0);
      query({4'hA, lfsr, lfsr});
      check("type_var", {56'h0, qt}, 64'h6);
      query({4'h4, lfsr, lfsr});
      check("type_default", {56'h0, qt}, 64'h5);
      $display("Test range map done");
      final_report();
   end
endmodule : range_unit_tb
`default_nettype wire
